// *** hw/stc_pkg.sv ***
// constants and types for the sensorless trapezoid commutator
package stc_pkg;
   localparam int unsigned CLK_HZ          = 10_000_000;
   // preset start delay, in seconds as specified
   localparam int unsigned PRESET_DELAY_S  = 90;
   localparam longint unsigned PRESET_DELAY_CYC =
      longint'(PRESET_DELAY_S) * longint'(CLK_HZ);
   // pwm period in ns, 20 kHz carrier
   localparam int unsigned PWM_PERIOD_NS   = 50_000;
   localparam int unsigned CLK_PERIOD_NS   = 100;
   localparam int unsigned PWM_PERIOD_CYC  = PWM_PERIOD_NS / CLK_PERIOD_NS;
   localparam int unsigned SAMPLE_W        = 10;
   localparam int unsigned ACC_W           = 20;
   localparam int unsigned DUTY_W          = 10;
   // default flux threshold
   localparam logic [ACC_W-1:0] FLUX_THR_RST = 20'h0012c;
   // speed duty presets, fraction of pwm period
   localparam logic [DUTY_W-1:0] DUTY_OFF  = 10'h000;
   localparam logic [DUTY_W-1:0] DUTY_LOW  = 10'h0c8;
   localparam logic [DUTY_W-1:0] DUTY_MED  = 10'h118;
   localparam logic [DUTY_W-1:0] DUTY_HIGH = 10'h190;
   localparam logic [DUTY_W-1:0] DUTY_HEAT = 10'h190;
   localparam logic [2:0] STEP_RST  = 3'h0;
   localparam logic [2:0] STEP_LAST = 3'h5;

   typedef enum logic [2:0] {
      STC_SPD_OFF, STC_SPD_LOW, STC_SPD_MED, STC_SPD_HIGH, STC_SPD_HEAT
   } stc_speed_type;
endpackage : stc_pkg

// *** hw/stc_commutator.sv ***
// six-step sensorless trapezoid commutator with preset speed selection
//
// Contract
// - low select: low fan speed after 90 s delay
// - medium select: medium fan speed after 90 s delay
// - high delayed select: high fan speed after 90 s delay
// - heat select: electric heat setting at once, no delay
// - high immediate select: high fan speed at once
// - six-step 120 degree commutation timed from integrated back-emf
// - each 60 degree step has two legs active, third leg fully off
// - pwm only on one high side, other leg low side held on
// - first step: pwm phase A high, phase C low on, B open
// - sample open phase in pwm on-time, subtract half bus
// - accumulate back-emf, commutate when sum reaches threshold
// - flux threshold is a programmable input
// - integration starts when open phase crosses half bus level
// - one open phase conversion per pwm period
module stc_commutator #(
   parameter longint unsigned DELAY_CYC = stc_pkg::PRESET_DELAY_CYC,
   parameter int unsigned     PWM_CYC   = stc_pkg::PWM_PERIOD_CYC
) (
   input  wire logic                         clk,
   input  wire logic                         rst_n,
   input  wire logic                         preset_low_select,
   input  wire logic                         preset_medium_select,
   input  wire logic                         preset_high_delayed_select,
   input  wire logic                         preset_heat_select,
   input  wire logic                         preset_high_immediate_select,
   input  wire logic [stc_pkg::ACC_W-1:0]    fluxThreshold,
   input  wire logic [stc_pkg::SAMPLE_W-1:0] openPhaseSample,
   input  wire logic [stc_pkg::SAMPLE_W-1:0] busSample,
   output logic                              phaseAHigh,
   output logic                              phaseALow,
   output logic                              phaseBHigh,
   output logic                              phaseBLow,
   output logic                              phaseCHigh,
   output logic                              phaseCLow,
   output logic                              sampleStrobe,
   output logic                              heatOn,
   output logic [2:0]                        commStep,
   output logic [stc_pkg::DUTY_W-1:0]        dutyActive
);
   localparam int unsigned CW = 40;
   localparam int unsigned PW = 16;
   localparam logic [CW-1:0] DELAY_LAST = CW'(DELAY_CYC - 1);
   localparam logic [PW-1:0] PWM_LAST   = PW'(PWM_CYC - 1);

   // two-stage synchronisers for the isolated preset lines
   logic [4:0] presetMeta_reg;
   logic [4:0] presetSync_reg;
   always_ff @(posedge clk) begin
      presetMeta_reg <= rst_n ? {preset_high_immediate_select,
         preset_heat_select, preset_high_delayed_select,
         preset_medium_select, preset_low_select} : 5'h00;
      presetSync_reg <= rst_n ? presetMeta_reg : 5'h00;
   end

   // preset decode; lowest line wins if several appear, which is illegal
   wire logic [4:0] sel = presetSync_reg;
   stc_pkg::stc_speed_type reqSpeed;
   wire logic reqDelayed = sel[0] | sel[1] | sel[2];
   assign reqSpeed = sel[0] ? stc_pkg::STC_SPD_LOW  :
                     sel[1] ? stc_pkg::STC_SPD_MED  :
                     sel[2] ? stc_pkg::STC_SPD_HIGH :
                     sel[3] ? stc_pkg::STC_SPD_HEAT :
                     sel[4] ? stc_pkg::STC_SPD_HIGH :
                              stc_pkg::STC_SPD_OFF;

   function automatic logic [stc_pkg::DUTY_W-1:0] speedDuty(
      input stc_pkg::stc_speed_type s);
      case (s)
         stc_pkg::STC_SPD_LOW:  speedDuty = stc_pkg::DUTY_LOW;
         stc_pkg::STC_SPD_MED:  speedDuty = stc_pkg::DUTY_MED;
         stc_pkg::STC_SPD_HIGH: speedDuty = stc_pkg::DUTY_HIGH;
         stc_pkg::STC_SPD_HEAT: speedDuty = stc_pkg::DUTY_HEAT;
         default:               speedDuty = stc_pkg::DUTY_OFF;
      endcase
   endfunction : speedDuty

   // delay timer; any change of selection restarts it
   logic [4:0]    selPrev_reg;
   logic [CW-1:0] delayCnt_reg;
   wire logic selChanged = (sel != selPrev_reg);
   wire logic delayDone  = (delayCnt_reg == DELAY_LAST);
   always_ff @(posedge clk) begin
      selPrev_reg <= rst_n ? sel : 5'h00;
      if (!rst_n || selChanged || !reqDelayed)
         delayCnt_reg <= '0;
      else if (!delayDone)
         delayCnt_reg <= delayCnt_reg + CW'(1);
   end

   // applied speed: delayed presets wait, heat and high-now apply at once
   stc_pkg::stc_speed_type speed_reg;
   stc_pkg::stc_speed_type speed_next;
   always_comb begin
      speed_next = speed_reg;
      if (reqDelayed)
         speed_next = (delayDone && !selChanged) ? reqSpeed
                                                 : stc_pkg::STC_SPD_OFF;
      else
         speed_next = reqSpeed;
   end
   always_ff @(posedge clk) begin
      speed_reg  <= rst_n ? speed_next : stc_pkg::STC_SPD_OFF;
      heatOn     <= rst_n && (speed_next == stc_pkg::STC_SPD_HEAT);
      dutyActive <= rst_n ? speedDuty(speed_next) : stc_pkg::DUTY_OFF;
   end

   // pwm carrier; sample point sits mid on-time
   logic [PW-1:0] pwmCnt_reg;
   always_ff @(posedge clk) begin
      if (!rst_n || pwmCnt_reg == PWM_LAST)
         pwmCnt_reg <= '0;
      else
         pwmCnt_reg <= pwmCnt_reg + PW'(1);
   end
   wire logic pwmOn = (PW'(dutyActive) > pwmCnt_reg);
   // one sample per period, taken in on-time
   wire logic samplePoint = pwmOn && (pwmCnt_reg == PW'(dutyActive >> 1));

   // back-emf: open phase minus half bus, signed
   wire logic signed [stc_pkg::SAMPLE_W:0] bemf =
      $signed({1'b0, openPhaseSample}) -
      $signed({2'b00, busSample[stc_pkg::SAMPLE_W-1:1]});

   // integrator and six-step sequencer
   logic [stc_pkg::ACC_W-1:0] acc_reg;
   logic                      integ_reg;
   logic [2:0]                step_reg;
   wire logic crossed  = sampleStrobe && !bemf[stc_pkg::SAMPLE_W];
   wire logic [stc_pkg::ACC_W-1:0] accAdd =
      acc_reg + stc_pkg::ACC_W'(unsigned'(bemf[stc_pkg::SAMPLE_W-1:0]));
   wire logic commutate = integ_reg && (acc_reg >= fluxThreshold);
   always_ff @(posedge clk) begin
      sampleStrobe <= rst_n && samplePoint;
      if (!rst_n) begin
         acc_reg   <= '0;
         integ_reg <= 1'b0;
         step_reg  <= stc_pkg::STEP_RST;
      end else if (commutate) begin
         acc_reg   <= '0;
         integ_reg <= 1'b0;
         step_reg  <= (step_reg == stc_pkg::STEP_LAST) ? stc_pkg::STEP_RST
                                                       : step_reg + 3'h1;
      end else if (crossed) begin
         // start at half-bus crossing; flux timing
         integ_reg <= 1'b1;
         acc_reg   <= accAdd;
      end
   end

   // step table: high-side pwm leg, low-side on leg
   logic [1:0] hiLeg;
   logic [1:0] loLeg;
   always_comb begin
      case (step_reg)
         3'h0:    begin hiLeg = 2'h0; loLeg = 2'h2; end
         3'h1:    begin hiLeg = 2'h1; loLeg = 2'h2; end
         3'h2:    begin hiLeg = 2'h1; loLeg = 2'h0; end
         3'h3:    begin hiLeg = 2'h2; loLeg = 2'h0; end
         3'h4:    begin hiLeg = 2'h2; loLeg = 2'h1; end
         3'h5:    begin hiLeg = 2'h0; loLeg = 2'h1; end
         default: begin hiLeg = 2'h0; loLeg = 2'h2; end
      endcase
   end
   wire logic run = (dutyActive != stc_pkg::DUTY_OFF);
   always_ff @(posedge clk) begin
      phaseAHigh <= rst_n && run && pwmOn && hiLeg == 2'h0;
      phaseBHigh <= rst_n && run && pwmOn && hiLeg == 2'h1;
      phaseCHigh <= rst_n && run && pwmOn && hiLeg == 2'h2;
      phaseALow  <= rst_n && run && loLeg == 2'h0;
      phaseBLow  <= rst_n && run && loLeg == 2'h1;
      phaseCLow  <= rst_n && run && loLeg == 2'h2;
      commStep   <= rst_n ? step_reg : stc_pkg::STEP_RST;
   end

   // never both switches of one leg
   property p_leg_safe;
      @(posedge clk) disable iff (!rst_n)
      !(phaseAHigh && phaseALow) && !(phaseBHigh && phaseBLow)
         && !(phaseCHigh && phaseCLow);
   endproperty
   a_leg_safe: assert property (p_leg_safe)
      else $error("leg shoot-through");
   property p_step0;
      @(posedge clk) disable iff (!rst_n)
      // lows lag dutyActive by one clock, so wait for a settled duty
      (commStep == 3'h0 && dutyActive != stc_pkg::DUTY_OFF
         && $stable(commStep) && $stable(dutyActive))
         |-> phaseCLow && !phaseCHigh && !phaseBHigh && !phaseBLow
             && !phaseALow;
   endproperty
   a_step0: assert property (p_step0)
      else $error("step zero pattern wrong");
   property p_adv;
      @(posedge clk) disable iff (!rst_n)
      // accumulator clear one clock on, new step on the output a clock later
      commutate |=> acc_reg == '0 ##1
         commStep == (($past(commStep, 2) == stc_pkg::STEP_LAST)
            ? stc_pkg::STEP_RST : $past(commStep, 2) + 3'h1);
   endproperty
   a_adv: assert property (p_adv)
      else $error("commutation did not advance");
   // immediate high applied within sync latency
   property p_now;
      @(posedge clk) disable iff (!rst_n)
      $rose(sel[4]) && sel[3:0] == 4'h0 |=> ##[0:2]
         dutyActive == stc_pkg::DUTY_HIGH;
   endproperty
   a_now: assert property (p_now)
      else $error("immediate high not applied");
   property p_hold;
      @(posedge clk) disable iff (!rst_n)
      $rose(sel[0]) |=> dutyActive == 10'h000 [*2];
   endproperty
   a_hold: assert property (p_hold)
      else $error("delayed preset applied early");
   property p_one_sample;
      @(posedge clk) disable iff (!rst_n)
      sampleStrobe |=> !sampleStrobe [*3];
   endproperty
   a_one_sample: assert property (p_one_sample)
      else $error("two samples in one period");
   property p_on;
      @(posedge clk) disable iff (!rst_n)
      sampleStrobe |-> phaseAHigh || phaseBHigh || phaseCHigh;
   endproperty
   a_on: assert property (p_on)
      else $error("sample outside on-time");
   property p_heat;
      @(posedge clk) disable iff (!rst_n)
      $rose(sel[3]) && sel[2:0] == 3'h0 |=> ##[0:2] heatOn;
   endproperty
   a_heat: assert property (p_heat)
      else $error("heat not entered");
endmodule : stc_commutator

// *** dv/stc_motor_model.sv ***
// behavioural inverter and motor feeding open phase and bus samples
module stc_motor_model (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       phaseAHigh,
   input  wire logic       phaseBHigh,
   input  wire logic       phaseCHigh,
   input  wire logic       sampleStrobe,
   input  wire logic [2:0] commStep,
   output logic      [9:0] openPhaseSample,
   output logic      [9:0] busSample
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] kCountReg;
   logic [2:0] stepSeenReg;
   logic [9:0] lastSampleReg;
   wire  logic highOn = phaseAHigh | phaseBHigh | phaseCHigh;
   // ramp crossing half bus
   // bemf starts 15 below center tap and climbs 10 per sample
   wire  logic [9:0] bemfLevel = 10'h0f1 + 10'(10 * kCountReg);
   assign busSample = 10'h200;
   // no pwm on-time: inverse of last value, so a stale read cannot pass
   assign openPhaseSample = highOn ? bemfLevel : ~lastSampleReg;
   // ramp restarts at every commutation, saturates to stay bounded
   always_ff @(posedge clk) begin
      if (!rst_n || commStep != stepSeenReg) begin
         kCountReg <= 4'h0;
      end else if (sampleStrobe && kCountReg != 4'hf) begin
         kCountReg <= kCountReg + 4'h1;
      end
      stepSeenReg <= commStep;
      if (!rst_n) begin
         lastSampleReg <= 10'h000;
      end else if (highOn) begin
         lastSampleReg <= bemfLevel;
      end
   end
endmodule : stc_motor_model

// *** dv/tb_stc_commutator.sv ***
// self-checking bench for the trapezoid commutator
module tb_stc_commutator;
   timeunit 1ns;
   timeprecision 1ns;
   localparam longint unsigned DLY = 50;  // short start delay for sim
   localparam int HI_LEG [6] = '{0, 1, 1, 2, 2, 0};
   localparam int LO_LEG [6] = '{2, 2, 0, 0, 1, 1};
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [4:0]  preset = 5'h00;
   logic [19:0] fluxThreshold = 20'hfffff;
   logic [9:0]  openPhaseSample, busSample, dutyActive;
   logic        phaseAHigh, phaseALow, phaseBHigh, phaseBLow;
   logic        phaseCHigh, phaseCLow, sampleStrobe, heatOn;
   logic [2:0]  commStep, s;
   int          badCount = 0;
   int          nCompared = 0;
   int          n;
   always #50 clk = ~clk;
   // full-length carrier: duty presets count clocks of the default period
   stc_commutator #(
      .DELAY_CYC(DLY),
      .PWM_CYC  (stc_pkg::PWM_PERIOD_CYC)
   ) stc_commutator_i (
      .clk(clk), .rst_n(rst_n), .preset_low_select(preset[0]),
      .preset_medium_select(preset[1]),
      .preset_high_delayed_select(preset[2]),
      .preset_heat_select(preset[3]),
      .preset_high_immediate_select(preset[4]),
      .fluxThreshold(fluxThreshold), .openPhaseSample(openPhaseSample),
      .busSample(busSample), .phaseAHigh(phaseAHigh),
      .phaseALow(phaseALow), .phaseBHigh(phaseBHigh),
      .phaseBLow(phaseBLow), .phaseCHigh(phaseCHigh),
      .phaseCLow(phaseCLow), .sampleStrobe(sampleStrobe),
      .heatOn(heatOn), .commStep(commStep), .dutyActive(dutyActive));
   stc_motor_model stc_motor_model_i (
      .clk(clk), .rst_n(rst_n), .phaseAHigh(phaseAHigh),
      .phaseBHigh(phaseBHigh), .phaseCHigh(phaseCHigh),
      .sampleStrobe(sampleStrobe), .commStep(commStep),
      .openPhaseSample(openPhaseSample), .busSample(busSample));
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      nCompared++;
      if (got !== exp) begin
         badCount++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int c);
      repeat (c) @(negedge clk);
   endtask : cyc
   task automatic setPreset(input logic [4:0] p);
      @(negedge clk);
      preset = p;
   endtask : setPreset
   // strobes that the model ramp needs to reach the threshold
   function automatic int expStrobes(input int thr);
      int sum = 0;
      for (int k = 0; k < 16; k++) begin
         if (10 * k - 15 >= 0) sum += 10 * k - 15;
         if (sum >= thr) return k + 1;
      end
      return 0;
   endfunction : expStrobes
   task automatic checkGates(input logic [2:0] st);
      chk(20'({phaseCLow, phaseBLow, phaseALow}), 20'(1 << LO_LEG[st]));
      // called in on-time, so the pwm leg must be on and the others off
      chk(20'({phaseCHigh, phaseBHigh, phaseAHigh}), 20'(1 << HI_LEG[st]));
   endtask : checkGates
   // counts strobes until the step moves, bounded
   task automatic interval(output int cnt);
      logic [2:0] st;
      int t;
      st = commStep;
      cnt = 0;
      t = 0;
      while (commStep === st && t < 4000) begin
         @(negedge clk);
         cnt += int'(sampleStrobe === 1'b1);
         t++;
      end
      if (t >= 4000) chk(20'(commStep), 20'(st + 3'h1));
   endtask : interval
   task automatic completeRun;
      $display("compared %0d mismatches %0d", nCompared, badCount);
      if (badCount == 0 && nCompared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : completeRun
   // watchdog well beyond the expected 22700 cycles of nine intervals
   initial begin
      repeat (40000) @(posedge clk);
      badCount++;
      completeRun();
   end
   initial begin
      cyc(6);
      rst_n = 1'b1;
      chk(20'(dutyActive), 20'(stc_pkg::DUTY_OFF));
      setPreset(5'h10);
      cyc(4);
      chk(20'(dutyActive), 20'(stc_pkg::DUTY_HIGH));
      chk(20'(heatOn), 20'h0);
      cyc(2);
      chk(20'(commStep), 20'h0);
      checkGates(3'h0);
      setPreset(5'h08);
      cyc(4);
      chk(20'(heatOn), 20'h1);
      chk(20'(dutyActive), 20'(stc_pkg::DUTY_HEAT));
      for (int i = 0; i < 3; i++) begin
         setPreset(5'h00);
         cyc(4);
         setPreset(5'(1 << i));
         cyc(48);
         chk(20'(dutyActive), 20'(stc_pkg::DUTY_OFF));
         cyc(10);
         chk(20'(dutyActive), 20'(i == 0 ? stc_pkg::DUTY_LOW :
             i == 1 ? stc_pkg::DUTY_MED : stc_pkg::DUTY_HIGH));
      end
      setPreset(5'h00);
      cyc(4);
      setPreset(5'h01);
      cyc(40);
      setPreset(5'h02);
      cyc(30);
      chk(20'(dutyActive), 20'(stc_pkg::DUTY_OFF));
      cyc(30);
      chk(20'(dutyActive), 20'(stc_pkg::DUTY_MED));
      setPreset(5'h10);
      fluxThreshold = 20'h00028;
      interval(n);
      for (int i = 0; i < 6; i++) begin
         s = commStep;
         cyc(2);
         checkGates(s);
         interval(n);
         chk(20'(n), 20'(expStrobes(40)));
         chk(20'(commStep), 20'(s == 3'h5 ? 3'h0 : s + 3'h1));
      end
      fluxThreshold = 20'h0003c;
      interval(n);
      interval(n);
      chk(20'(n), 20'(expStrobes(60)));
      completeRun();
   end
endmodule : tb_stc_commutator
